// file: hw/srsel_pkg.sv
// Purpose: Constants and types shared by the status output selector.
// Assumes: 10 MHz clock; frequencies in 0.01 Hz steps on 16 bits.
// Notes: Mode codes are the values software writes to the selectors.
package srsel_pkg;
	// Selectable indication modes
	typedef enum logic [3:0] {
		SRSEL_NONE,
		SRSEL_RUN,
		SRSEL_FAULT,
		SRSEL_INV_FAULT,
		SRSEL_LOCKOUT,
		SRSEL_AT_SPEED,
		SRSEL_ABOVE3,
		SRSEL_CUR_LIMIT,
		SRSEL_AUTO_MANUAL
	} srsel_mode_t;

	// Register bus
	localparam int          ADDR_W      = 4;
	localparam logic [3:0]  OFS_SEL0    = 4'h0;   // Relay selector
	localparam logic [3:0]  OFS_SEL1    = 4'h1;   // Open-collector 1 selector
	localparam logic [3:0]  OFS_SEL2    = 4'h2;   // Open-collector 2 selector
	localparam logic [3:0]  OFS_STATUS  = 4'h3;   // Output and condition state
	localparam logic [3:0]  SEL_RESET   = 4'h0;   // Disabled after reset

	// Frequencies, 0.01 Hz per count
	localparam logic [15:0] STOP_FREQ   = 16'h0032; // 0.5 Hz
	localparam logic [15:0] SPEED_HYST  = 16'h012c; // 3 Hz
	localparam logic [2:0]  RESTART_MAX = 3'h5;     // Failed restarts before lockout

	// Current limit hold time
	localparam int          CLK_HZ      = 10_000_000;
	localparam int          HOLD_MS     = 500;
	localparam int          HOLD_CYC    = CLK_HZ / 1000 * HOLD_MS;
endpackage : srsel_pkg

// file: hw/srsel_hold_timer.sv
// Purpose: Minimum-on timer for the current limit indication.
// Assumes: limIn is synchronous to clk.
// Notes: Restarts on each rising edge of limIn.
`timescale 1ns/1ps
module srsel_hold_timer #(
	parameter int HOLD_CYC = srsel_pkg::HOLD_CYC
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic limIn,
	output logic      holdOut
);
	logic        limDly_r;   // Previous limIn
	logic [22:0] cnt_r;      // Remaining hold cycles

	// Count down from entry; re-arm on each new entry
	always_ff @(posedge clk) begin
		if (!rstn) begin
			limDly_r <= 1'b0;
			cnt_r    <= 23'h0;
		end else begin
			limDly_r <= limIn;
			if (limIn && !limDly_r) begin
				cnt_r <= 23'(HOLD_CYC);
			end else if (cnt_r != 23'h0) begin
				cnt_r <= cnt_r - 23'h1;
			end
		end
	end

	// Held while the interval runs or the limit persists
	assign holdOut = (cnt_r != 23'h0) || limIn;

	// Each new entry reloads the full interval
	lim_entry_a: assert property (@(posedge clk) disable iff (!rstn)
		limIn && !limDly_r |=> cnt_r == 23'(HOLD_CYC))
		else $error("hold not reloaded on entry");
endmodule : srsel_hold_timer

// file: hw/srsel_top.sv
// Purpose: Drives one relay and two open-collector status outputs from drive state.
// Assumes: Drive state inputs are asynchronous and get two-stage synchronisers.
// Notes: Outputs are registered; power loss is modelled by reset or powerOk low.
`timescale 1ns/1ps
// Contract
// - Three programmable outputs: relay, two collectors
// - Disabled setting holds output off
// - Run: on start, off below 0.5Hz/trip
// - Fault: on with power, off on trip
// - Inverse fault: on at trip until cleared
// - Lockout: off after five failed restarts
// - At speed with 3 Hz hysteresis
// - On while frequency above preset three
// - Current limit held at least 500ms
// - On in automatic, off in manual
// - Protection trips form the fault event
module srsel_top #(
	parameter int HOLD_CYC = srsel_pkg::HOLD_CYC
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [3:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [7:0]       regRdata,
	input  wire logic        powerOk,
	input  wire logic        startCmd,
	input  wire logic        stopCmd,
	input  wire logic [3:0]  protTrip,
	input  wire logic        faultClear,
	input  wire logic        restartFail,
	input  wire logic        autoRef,
	input  wire logic        curLimit,
	input  wire logic [15:0] outFreq,
	input  wire logic [15:0] setFreq,
	input  wire logic [15:0] preset3Freq,
	output logic             relayOut,
	output logic [1:0]       collectorOut
);
	localparam int NBIT = 10;  // Synchronised single-bit inputs

	// Two-stage synchronisers for all asynchronous single-bit inputs
	// Levels only: a pulse shorter than one clock may be lost here
	logic [NBIT-1:0] rawIn;
	logic [NBIT-1:0] syncA_r;   // First stage, read only by syncB_r
	logic [NBIT-1:0] syncB_r;   // Usable copies
	assign rawIn = {powerOk, startCmd, stopCmd, protTrip, faultClear, restartFail, autoRef};
	// curLimit is handled separately below

	always_ff @(posedge clk) begin
		if (!rstn) begin
			syncA_r <= '0;
			syncB_r <= '0;
		end else begin
			syncA_r <= rawIn;
			syncB_r <= syncA_r;
		end
	end

	logic       pwrS;        // Input power present
	logic       startS;      // Start command
	logic       stopS;       // Stop command
	logic [3:0] tripS;       // Protection circuit trips
	logic       clrS;        // Fault cleared
	logic       rfailS;      // Failed restart attempt
	logic       autoS;       // Automatic reference
	assign {pwrS, startS, stopS, tripS, clrS, rfailS, autoS} = syncB_r;

	// Current limit synchroniser
	logic limA_r;
	logic limB_r;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			limA_r <= 1'b0;
			limB_r <= 1'b0;
		end else begin
			limA_r <= curLimit;
			limB_r <= limA_r;
		end
	end

	// Frequency words: two register stages as well; a torn word lasts one cycle
	// The drive holds each word steady for many clocks, so no handshake
	logic [15:0] fOutA_r;   // Output frequency, first stage
	logic [15:0] fOutB_r;   // Output frequency, usable
	logic [15:0] fSetA_r;   // Set point, first stage
	logic [15:0] fSetB_r;   // Set point, usable
	logic [15:0] fP3A_r;    // Third preset, first stage
	logic [15:0] fP3B_r;    // Third preset, usable
	always_ff @(posedge clk) begin
		if (!rstn) begin
			fOutA_r <= 16'h0;
			fOutB_r <= 16'h0;
			fSetA_r <= 16'h0;
			fSetB_r <= 16'h0;
			fP3A_r  <= 16'h0;
			fP3B_r  <= 16'h0;
		end else begin
			fOutA_r <= outFreq;
			fOutB_r <= fOutA_r;
			fSetA_r <= setFreq;
			fSetB_r <= fSetA_r;
			fP3A_r  <= preset3Freq;
			fP3B_r  <= fP3A_r;
		end
	end

	// Any protection circuit shuts the drive down in fault
	logic tripEv;
	assign tripEv = |tripS;

	// Selector registers, one per output
	logic [3:0] sel_r [3];
	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < 3; i++) sel_r[i] <= srsel_pkg::SEL_RESET;
		end else if (regWr) begin
			if (regAddr == srsel_pkg::OFS_SEL0) sel_r[0] <= regWdata[3:0];
			if (regAddr == srsel_pkg::OFS_SEL1) sel_r[1] <= regWdata[3:0];
			if (regAddr == srsel_pkg::OFS_SEL2) sel_r[2] <= regWdata[3:0];
		end
	end

	// Fault latch: set wins over clear
	// Power loss empties the latch, so a restart begins clean
	logic faulted_r;
	always_ff @(posedge clk) begin
		if (!rstn || !pwrS) begin
			faulted_r <= 1'b0;
		end else if (tripEv) begin
			faulted_r <= 1'b1;
		end else if (clrS) begin
			faulted_r <= 1'b0;
		end
	end

	// Run mode latch and the stop request that waits for the ramp down
	logic running_r;    // Drive in run mode
	logic stopPend_r;   // Stop given, output not yet down to the stop frequency

	// Run mode latch; it shows run mode, not shaft motion
	always_ff @(posedge clk) begin
		if (!rstn || !pwrS || tripEv) begin
			running_r <= 1'b0;
		end else if (startS) begin
			running_r <= 1'b1;
		end else if ((stopS || stopPend_r) && fOutB_r <= srsel_pkg::STOP_FREQ) begin
			running_r <= 1'b0;
		end
	end

	// A stop command may be short while the ramp down is long: remember it
	always_ff @(posedge clk) begin
		if (!rstn || !pwrS || tripEv) begin
			stopPend_r <= 1'b0; // Run already ended
		end else if (startS) begin
			stopPend_r <= 1'b0; // New start cancels the stop
		end else if (stopS && running_r) begin
			stopPend_r <= 1'b1;
		end else if (!running_r) begin
			stopPend_r <= 1'b0; // Nothing left to stop
		end
	end

	// Ramp-down after a stop ends run mode
	stop_drop_a: assert property (@(posedge clk) disable iff (!rstn)
		running_r && stopPend_r && !startS && fOutB_r <= srsel_pkg::STOP_FREQ |=> !running_r)
		else $error("run kept after stop");

	// Failed restart counter; edge detected on the synchronised copy
	// Counting stops once locked; only power loss or reset unlocks
	logic       rfailD_r;
	logic [2:0] rfailCnt_r;
	logic       locked_r;
	always_ff @(posedge clk) begin
		if (!rstn || !pwrS) begin
			rfailD_r   <= 1'b0;
			rfailCnt_r <= 3'h0;
			locked_r   <= 1'b0;
		end else begin
			rfailD_r <= rfailS;
			if (rfailS && !rfailD_r && faulted_r && !locked_r) begin
				rfailCnt_r <= rfailCnt_r + 3'h1;
				if (rfailCnt_r + 3'h1 == srsel_pkg::RESTART_MAX) locked_r <= 1'b1;
			end
		end
	end

	// At-speed with hysteresis band
	// Exact match to enter, a full band of difference to leave
	logic [15:0] fDiff;
	logic        atSpeed_r;
	assign fDiff = (fOutB_r > fSetB_r) ? fOutB_r - fSetB_r : fSetB_r - fOutB_r;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			atSpeed_r <= 1'b0;
		end else if (!atSpeed_r && fOutB_r == fSetB_r && running_r) begin
			atSpeed_r <= 1'b1;
		end else if (atSpeed_r && (fDiff >= srsel_pkg::SPEED_HYST || !running_r)) begin
			atSpeed_r <= 1'b0;
		end
	end

	// Current limit minimum hold
	// The timer sits after the synchroniser, so the hold counts from the seen edge
	logic limHold;
	srsel_hold_timer #(.HOLD_CYC(HOLD_CYC)) uHold (
		.clk     (clk),
		.rstn    (rstn),
		.limIn   (limB_r),
		.holdOut (limHold)
	);

	// Condition per mode
	// Every mode reads registered state, so an output follows its
	// condition one clock after the state changes
	function automatic logic pick(input logic [3:0] m, input logic run, input logic flt,
		input logic lck, input logic spd, input logic abv, input logic lim,
		input logic aut, input logic pw);
		case (srsel_pkg::srsel_mode_t'(m))
			srsel_pkg::SRSEL_NONE:        pick = 1'b0;
			srsel_pkg::SRSEL_RUN:         pick = run;
			srsel_pkg::SRSEL_FAULT:       pick = pw && !flt;
			srsel_pkg::SRSEL_INV_FAULT:   pick = flt;
			srsel_pkg::SRSEL_LOCKOUT:     pick = pw && !lck;
			srsel_pkg::SRSEL_AT_SPEED:    pick = spd;
			srsel_pkg::SRSEL_ABOVE3:      pick = abv;
			srsel_pkg::SRSEL_CUR_LIMIT:   pick = lim;
			srsel_pkg::SRSEL_AUTO_MANUAL: pick = aut;
			default:                      pick = 1'b0;            // Unused codes stay off
		endcase
	endfunction

	// Registered outputs, one per selector
	// Loss of supply drops all three together, whatever each selects
	logic [2:0] outs_r;
	logic       above3;
	assign above3 = fOutB_r > fP3B_r;
	generate
		for (genvar g = 0; g < 3; g++) begin : gOut
			always_ff @(posedge clk) begin
				if (!rstn || !pwrS) begin
					outs_r[g] <= 1'b0;
				end else begin
					outs_r[g] <= pick(sel_r[g], running_r, faulted_r, locked_r, atSpeed_r,
						above3, limHold, autoS, pwrS);
				end
			end
		end
	endgenerate
	assign relayOut     = outs_r[0];
	assign collectorOut = outs_r[2:1];

	// Read port, data in the following cycle
	// Reads have no side effects; status bits are live copies
	always_ff @(posedge clk) begin
		if (!rstn) begin
			regRdata <= 8'h0;
		end else if (regRd) begin
			case (regAddr)
				srsel_pkg::OFS_SEL0:   regRdata <= {4'h0, sel_r[0]};
				srsel_pkg::OFS_SEL1:   regRdata <= {4'h0, sel_r[1]};
				srsel_pkg::OFS_SEL2:   regRdata <= {4'h0, sel_r[2]};
				srsel_pkg::OFS_STATUS: regRdata <= {running_r, faulted_r, locked_r, atSpeed_r,
					limHold, outs_r};
				default:               regRdata <= 8'h0;
			endcase
		end else begin
			regRdata <= 8'h0;
		end
	end

	// Disabled selector never drives the relay
	relay_off_a: assert property (@(posedge clk) disable iff (!rstn)
		sel_r[0] == 4'h0 |=> !relayOut)
		else $error("relay on while disabled");

	// Disabled second collector stays off
	coll_off_a: assert property (@(posedge clk) disable iff (!rstn)
		sel_r[2] == 4'h0 |=> !collectorOut[1])
		else $error("collector on while disabled");

	// Trip clears the run indication
	run_trip_a: assert property (@(posedge clk) disable iff (!rstn)
		tripEv |=> !running_r)
		else $error("run kept after trip");

	// Run mode reaches the relay one clock later
	relay_run_a: assert property (@(posedge clk) disable iff (!rstn)
		sel_r[0] == 4'(srsel_pkg::SRSEL_RUN) && pwrS |=> relayOut == $past(running_r))
		else $error("relay does not follow run");

	// Fault mode: on with power, off once tripped
	fault_mode_a: assert property (@(posedge clk) disable iff (!rstn)
		sel_r[1] == 4'(srsel_pkg::SRSEL_FAULT) && pwrS |=> collectorOut[0] == !$past(faulted_r))
		else $error("fault mode output wrong");

	// Inverse fault follows trip
	inv_fault_a: assert property (@(posedge clk) disable iff (!rstn)
		tripEv && pwrS |=> faulted_r)
		else $error("fault not latched");

	// Clearing without a new trip empties the latch
	fault_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		faulted_r && clrS && !tripEv && pwrS |=> !faulted_r)
		else $error("fault kept after clear");

	// Fifth failed restart locks the output off
	lock_count_a: assert property (@(posedge clk) disable iff (!rstn)
		rfailS && !rfailD_r && faulted_r && pwrS
			&& rfailCnt_r == srsel_pkg::RESTART_MAX - 3'h1 |=> locked_r)
		else $error("lockout not taken");

	// Lockout mode shows the inverse of the lock
	lock_out_a: assert property (@(posedge clk) disable iff (!rstn)
		sel_r[0] == 4'(srsel_pkg::SRSEL_LOCKOUT) && pwrS |=> relayOut == !$past(locked_r))
		else $error("lockout output wrong");

	// Inside the band the at-speed flag holds
	speed_band_a: assert property (@(posedge clk) disable iff (!rstn)
		atSpeed_r && running_r && fDiff < srsel_pkg::SPEED_HYST |=> atSpeed_r)
		else $error("at speed dropped inside band");

	// Above-preset mode tracks the comparison
	above_pre_a: assert property (@(posedge clk) disable iff (!rstn)
		sel_r[0] == 4'(srsel_pkg::SRSEL_ABOVE3) && pwrS |=> relayOut == $past(above3))
		else $error("above preset output wrong");

	// Hold keeps current limit output up
	lim_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(limB_r) |=> limHold [*8])
		else $error("limit hold dropped early");

	// Limit mode shows the held limit
	lim_mode_a: assert property (@(posedge clk) disable iff (!rstn)
		sel_r[0] == 4'(srsel_pkg::SRSEL_CUR_LIMIT) && pwrS |=> relayOut == $past(limHold))
		else $error("limit output wrong");

	// Reference mode shows automatic as on
	auto_ref_a: assert property (@(posedge clk) disable iff (!rstn)
		sel_r[0] == 4'(srsel_pkg::SRSEL_AUTO_MANUAL) && pwrS |=> relayOut == $past(autoS))
		else $error("reference output wrong");

	// Power loss forces outputs off
	pwr_off_a: assert property (@(posedge clk) disable iff (!rstn)
		!pwrS |=> outs_r == 3'h0)
		else $error("output on without power");

	// Read data stands one cycle only
	rd_idle_a: assert property (@(posedge clk) disable iff (!rstn)
		!regRd |=> regRdata == 8'h0)
		else $error("read data outside its cycle");

	// Selector read returns the stored code
	sel_read_a: assert property (@(posedge clk) disable iff (!rstn)
		regRd && regAddr == srsel_pkg::OFS_SEL0 |=> regRdata == {4'h0, $past(sel_r[0])})
		else $error("selector read wrong");
endmodule : srsel_top

// file: verif/srsel_sense_model.sv
// Purpose: External wiring that senses the relay and the two collectors.
// Assumes: Contacts are read as energized or not, one clk late.
// Notes: Off-state lines read 0 here, like a pulled-down sense input.
`timescale 1ns/1ps
module srsel_sense_model (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       relayOut,
	input  wire logic [1:0] collectorOut,
	output logic      [2:0] sensed
);
	// Sample all three contacts together so they line up in time
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sensed <= 3'h0;
		end else begin
			sensed <= {collectorOut, relayOut};
		end
	end
endmodule : srsel_sense_model

// file: verif/testbench.sv
// Purpose: Self-checking bench for the status output selector.
// Assumes: Hold time shortened to 20 cycles; settle time 10 cycles.
// Notes: Drive inputs change by non-blocking assignment on clk.
`timescale 1ns/1ps
module testbench;
	logic        clk = 0, rstn = 0, regWr = 0, regRd = 0, powerOk = 0;
	logic        startCmd = 0, stopCmd = 0, faultClear = 0, restartFail = 0;
	logic        autoRef = 0, curLimit = 0, relayOut;
	logic [3:0]  regAddr = 4'h0, protTrip = 4'h0;
	logic [7:0]  regWdata = 8'h00, regRdata, rd;
	logic [15:0] outFreq = 16'h0000, setFreq = 16'h1770, preset3Freq = 16'h0bb8;
	logic [1:0]  collectorOut;
	logic [2:0]  sensed;
	int          n_fail = 0, num_checks = 0;
	always #50 clk = ~clk; // 10 MHz
	srsel_top #(.HOLD_CYC(20)) srsel_top_inst (.clk(clk), .rstn(rstn), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.powerOk(powerOk), .startCmd(startCmd), .stopCmd(stopCmd), .protTrip(protTrip),
		.faultClear(faultClear), .restartFail(restartFail), .autoRef(autoRef),
		.curLimit(curLimit), .outFreq(outFreq), .setFreq(setFreq),
		.preset3Freq(preset3Freq), .relayOut(relayOut), .collectorOut(collectorOut));
	srsel_sense_model srsel_sense_model_inst (.clk(clk), .rstn(rstn), .relayOut(relayOut),
		.collectorOut(collectorOut), .sensed(sensed));
	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1; regAddr <= a; regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	// Data stands only in the cycle after the strobe
	task automatic rdreg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		regRd <= 1'b1; regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask : rdreg
	// Let synchronisers and the sense model settle
	task automatic settle(input int n = 10);
		repeat (n) @(posedge clk);
	endtask : settle
	// Line codes: a ref argument may not take a non-blocking assignment
	localparam int L_START = 0;
	localparam int L_STOP  = 1;
	localparam int L_CLR   = 2;
	localparam int L_RFAIL = 3;
	localparam int L_LIM   = 4;
	task automatic set_line(input int k, input logic v);
		case (k)
			L_START: startCmd    <= v;
			L_STOP:  stopCmd     <= v;
			L_CLR:   faultClear  <= v;
			L_RFAIL: restartFail <= v;
			default: curLimit    <= v;
		endcase
	endtask : set_line
	task automatic pulse(input int k);
		@(posedge clk);
		set_line(k, 1'b1);
		settle(3);
		set_line(k, 1'b0);
		settle(3);
	endtask : pulse
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : close_out
	// Watchdog so a hang still reaches the verdict
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		chk({5'h0, relayOut, collectorOut}, 8'h00);
		for (int i = 0; i < 3; i++) begin
			rdreg(i[3:0], rd); chk(rd, {4'h0, srsel_pkg::SEL_RESET});
		end
		wr(srsel_pkg::OFS_SEL0, 8'(srsel_pkg::SRSEL_RUN));
		wr(srsel_pkg::OFS_SEL1, 8'(srsel_pkg::SRSEL_FAULT));
		wr(srsel_pkg::OFS_SEL2, 8'(srsel_pkg::SRSEL_INV_FAULT));
		rdreg(srsel_pkg::OFS_SEL2, rd); chk(rd, 8'h03);
		rdreg(4'h7, rd); chk(rd, 8'h00);
		settle(); chk({5'h0, sensed}, 8'h00);
		powerOk <= 1'b1; settle(); chk({5'h0, sensed}, 8'h02);
		outFreq <= 16'h1770; pulse(L_START); settle(); chk({5'h0, sensed}, 8'h03);
		// Run, fault ok and at speed all show in the status word
		rdreg(srsel_pkg::OFS_STATUS, rd); chk(rd, 8'h93);
		// Every protection source trips the fault modes
		for (int i = 0; i < 4; i++) begin
			protTrip <= 4'h1 << i; settle(); chk({5'h0, sensed}, 8'h04);
			protTrip <= 4'h0; settle(); chk({5'h0, sensed}, 8'h04);
			pulse(L_CLR); settle(); chk({5'h0, sensed}, 8'h02);
		end
		$display("test fault modes done");
		pulse(L_START); pulse(L_STOP); settle(); chk({5'h0, sensed}, 8'h03);
		outFreq <= 16'h0031; settle(); chk({5'h0, sensed}, 8'h02);
		wr(srsel_pkg::OFS_SEL1, 8'(srsel_pkg::SRSEL_NONE)); settle();
		chk({5'h0, sensed}, 8'h00);
		$display("test run mode done");
		wr(srsel_pkg::OFS_SEL0, 8'(srsel_pkg::SRSEL_LOCKOUT)); settle();
		chk({7'h0, sensed[0]}, 8'h01);
		protTrip <= 4'h2; settle();
		for (int i = 0; i < 4; i++) pulse(L_RFAIL);
		settle(); chk({7'h0, sensed[0]}, 8'h01);
		pulse(L_RFAIL); settle(); chk({7'h0, sensed[0]}, 8'h00);
		protTrip <= 4'h0; pulse(L_CLR); powerOk <= 1'b0; settle();
		chk({5'h0, sensed}, 8'h00);
		powerOk <= 1'b1; settle(); chk({7'h0, sensed[0]}, 8'h01);
		$display("test lockout done");
		wr(srsel_pkg::OFS_SEL0, 8'(srsel_pkg::SRSEL_AT_SPEED));
		outFreq <= 16'h1770; pulse(L_START); settle(); chk({7'h0, sensed[0]}, 8'h01);
		outFreq <= 16'h1770 - 16'h012b; settle(); chk({7'h0, sensed[0]}, 8'h01);
		outFreq <= 16'h1770 - srsel_pkg::SPEED_HYST; settle(); chk({7'h0, sensed[0]}, 8'h00);
		wr(srsel_pkg::OFS_SEL0, 8'(srsel_pkg::SRSEL_ABOVE3));
		outFreq <= 16'h0bb9; settle(); chk({7'h0, sensed[0]}, 8'h01);
		outFreq <= 16'h0bb7; settle(); chk({7'h0, sensed[0]}, 8'h00);
		wr(srsel_pkg::OFS_SEL0, 8'(srsel_pkg::SRSEL_AUTO_MANUAL));
		autoRef <= 1'b1; settle(); chk({7'h0, sensed[0]}, 8'h01);
		autoRef <= 1'b0; settle(); chk({7'h0, sensed[0]}, 8'h00);
		$display("test speed and reference done");
		// Short limit pulse still gives the full hold, then drops
		wr(srsel_pkg::OFS_SEL0, 8'(srsel_pkg::SRSEL_CUR_LIMIT));
		pulse(L_LIM); chk({7'h0, sensed[0]}, 8'h01);
		settle(8); chk({7'h0, sensed[0]}, 8'h01);
		settle(30); chk({7'h0, sensed[0]}, 8'h00);
		curLimit <= 1'b1; settle(40); chk({7'h0, sensed[0]}, 8'h01);
		curLimit <= 1'b0; settle(40); chk({7'h0, sensed[0]}, 8'h00);
		rstn <= 1'b0; settle(2); chk({5'h0, relayOut, collectorOut}, 8'h00);
		$display("test current limit done");
		close_out();
	end
endmodule : testbench
